// *** shared/shutoff_consts.vh ***
// Constants for the torque-shutoff monitor: register offsets, field positions,
// alarm codes and timing figures.
// Assumes a 250 MHz system clock and a 32-bit register port with byte addresses.
`ifndef SHUTOFF_CONSTS_VH
`define SHUTOFF_CONSTS_VH

// Clock rate in MHz, used to turn times into cycle counts.
`define CLK_MHZ                 250

// Register byte offsets.
`define OFS_SERVO_FUNC_EIGHT    8'h00
`define OFS_STATUS              8'h04
`define OFS_IRQ_STATUS          8'h08
`define OFS_IRQ_MASK            8'h0C
`define OFS_ALARM_CODES         8'h10

// Field positions.
`define WIRED_USE_BIT           8
`define FUNC_WORD_W             16
`define FUNC_WORD_RESET         16'h0000

// Interrupt status bit positions.
`define IRQ_WARN_BIT            0
`define IRQ_ERR_BIT             1
`define IRQ_INPUT_BIT           2
`define IRQ_W                   3

// Warning and error codes with their sub-numbers.
`define WARN_CODE               8'hA4
`define WARN_SUB_SHUTOFF        16'h0001
`define ERR_CODE                8'h4D
`define ERR_SUB_NONE            16'h0000
`define ERR_SUB_PARAM           16'h0001
`define ERR_SUB_REQ_SERVO_ON    16'h0002
`define ERR_SUB_MISMATCH_OFF    16'h0004
`define ERR_SUB_MISMATCH_ON     16'h0006

// Input filter time in microseconds; the worst-case reaction is 30 ms.
`define SHUTOFF_FILTER_US       10000
`define SHUTOFF_REACT_MAX_US    30000
`define SHUTOFF_FILTER_CYCLES   (`SHUTOFF_FILTER_US * `CLK_MHZ)
// Time two channels may disagree before an error is raised.
`define MISMATCH_US             10000
`define MISMATCH_CYCLES         (`MISMATCH_US * `CLK_MHZ)

`endif

// *** design/shutoff_input_filter.v ***
// One wired shutoff channel: two-stage synchroniser followed by a debounce filter.
// Assumes the raw input is a slow contact level with chatter of at most 1 ms.
`timescale 1ns/1ps

module shutoff_input_filter #(
    parameter             CNT_W         = 24,
    parameter [CNT_W-1:0] FILTER_CYCLES = 24'h2625A0
) (
    // Clock and reset.
    input  wire clk_i,
    input  wire rst_n_i,
    // Raw contact level and its conditioned copies.
    input  wire raw_i,
    output wire sync_o,
    output wire level_o
);

    reg             meta_r;
    reg             sync_r;
    reg             level_r;
    reg [CNT_W-1:0] cnt_r;

    assign sync_o  = sync_r;
    assign level_o = level_r;

    // The first stage feeds only the second; everything else looks at sync_r.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= raw_i;
            sync_r <= meta_r;
        end
    end

    // A new level is accepted only after it has stood for the whole filter time,
    // so contact bounce never reaches the shutoff or the checks.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r   <= {CNT_W{1'b0}};
            level_r <= 1'b0;
        end else if (sync_r == level_r) begin
            cnt_r <= {CNT_W{1'b0}};
        end else if (cnt_r >= FILTER_CYCLES - 1'b1) begin
            cnt_r   <= {CNT_W{1'b0}};
            level_r <= sync_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

endmodule

// *** design/safe_torque_off_monitor.v ***
// Torque-shutoff monitor for one drive unit: network and wired shutoff, channel
// echo, warning and dual-signal error reporting, register port and interrupt.
// Assumes all inputs are synchronous to clk_i except the two wired channels.
// Filter and mismatch times are parameters so that a bench may shorten them.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "shutoff_consts.vh"

module safe_torque_off_monitor #(
    parameter              AXES            = 4,
    parameter              LOCAL_AXIS      = 0,
    parameter              CNT_W           = 24,
    parameter [CNT_W-1:0]  FILTER_CYCLES   = `SHUTOFF_FILTER_CYCLES,
    parameter [CNT_W-1:0]  MISMATCH_CYCLES = `MISMATCH_CYCLES
) (
    // Clock and reset.
    input  wire            clk_i,
    input  wire            rst_n_i,
    // Wired shutoff channels, high while shutoff is requested.
    input  wire            shutoff_in_a_i,
    input  wire            shutoff_in_b_i,
    // Drive state and controller requests.
    input  wire            net_shutoff_req_i,
    input  wire            servo_on_i,
    input  wire            nc_reset_i,
    // Register port.
    input  wire [7:0]      reg_addr_i,
    input  wire [31:0]     reg_wdata_i,
    input  wire            reg_we_i,
    input  wire            reg_re_i,
    output reg  [31:0]     reg_rdata_o,
    // Channel echoes.
    output reg             shutoff_echo_a_o,
    output reg             shutoff_echo_b_o,
    // Energy cut per axis, one independent path per channel.
    output reg  [AXES-1:0] energy_cut_a_o,
    output reg  [AXES-1:0] energy_cut_b_o,
    // Alarm state.
    output reg             warn_a4_o,
    output reg             axis_stop_o,
    output reg             irq_o
);

    // Conditioned channel levels. The synchronised copies feed only the echoes
    // and the status word; every decision uses the filtered levels.
    wire sync_a;
    wire sync_b;
    wire level_a;
    wire level_b;

    // Software-visible state. The function word resets to zero, so observation
    // stays off until software opts in.
    reg [`FUNC_WORD_W-1:0] func_word_r;
    reg [15:0]             err_sub_r;
    reg [15:0]             err_sub_nxt;
    reg [`IRQ_W-1:0]       irq_stat_r;
    reg [`IRQ_W-1:0]       irq_mask_r;
    reg [`IRQ_W-1:0]       irq_event;
    reg [CNT_W-1:0]        mis_cnt_r;
    reg                    mis_err;
    reg                    warn_nxt;
    reg                    level_a_d_r;
    reg                    level_b_d_r;
    reg                    warn_d_r;
    reg                    err_d_r;
    reg [AXES-1:0]         cut_a_nxt;
    reg [AXES-1:0]         cut_b_nxt;

    // Qualified channel views. A request counts against the running servo only
    // when both channels agree; a one-sided level is judged as a mismatch after
    // the mismatch time, which is the only way the servo-on mismatch can show.
    wire wired_use  = func_word_r[`WIRED_USE_BIT];
    wire wired_req  = level_a | level_b;
    wire mismatch   = level_a ^ level_b;
    wire wired_both = level_a & level_b;

    // Channel A conditioning.
    // The synchroniser sits inside the filter module, so nothing here reads the raw pin.
    shutoff_input_filter #(
        .CNT_W         (CNT_W),
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_filter_a (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .raw_i   (shutoff_in_a_i),
        .sync_o  (sync_a),
        .level_o (level_a)
    );

    // Channel B conditioning, kept apart from A so one fault cannot hit both.
    // The two filters share no counter and no state.
    shutoff_input_filter #(
        .CNT_W         (CNT_W),
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_filter_b (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .raw_i   (shutoff_in_b_i),
        .sync_o  (sync_b),
        .level_o (level_b)
    );

    // Energy cut for path A. The network request cuts every axis; channel A
    // cuts only the local axis. The configuration bit is deliberately absent
    // here, so a wrong setting can never leave the motor energised.
    always @* begin
        cut_a_nxt = {AXES{net_shutoff_req_i}};
        cut_a_nxt[LOCAL_AXIS] = net_shutoff_req_i | level_a;
    end

    // Energy cut for path B. It is kept in a process of its own and reads only
    // channel B, so a stuck channel A cannot hold path B open.
    always @* begin
        cut_b_nxt = {AXES{net_shutoff_req_i}};
        cut_b_nxt[LOCAL_AXIS] = net_shutoff_req_i | level_b;
    end

    // The warning stands whenever either path withholds energy, whatever the
    // configuration bit says. It clears by itself once the cause is gone.
    always @* begin
        warn_nxt = net_shutoff_req_i | level_a | level_b;
    end

    // Mismatch must persist for the mismatch time, which covers the skew of two
    // contacts that open together but not in the same microsecond.
    // The counter saturates at the limit, so a mismatch that stands for hours
    // cannot wrap it back into the silent range.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mis_cnt_r <= {CNT_W{1'b0}};
        end else if (!mismatch || !wired_use) begin
            mis_cnt_r <= {CNT_W{1'b0}};
        end else if (mis_cnt_r < MISMATCH_CYCLES) begin
            mis_cnt_r <= mis_cnt_r + 1'b1;
        end
    end

    // Error selection. Only the first cause is kept until a controller reset,
    // so the reported sub-number names what went wrong first. An agreed request
    // with the servo on is caught at once; a one-sided level waits for the
    // mismatch time and is then reported with the servo state of that moment.
    always @* begin
        mis_err     = (mis_cnt_r >= MISMATCH_CYCLES);
        err_sub_nxt = err_sub_r;
        if (nc_reset_i) begin
            err_sub_nxt = `ERR_SUB_NONE;
        end else if (err_sub_r == `ERR_SUB_NONE) begin
            if (wired_use && mis_err && servo_on_i) begin
                err_sub_nxt = `ERR_SUB_MISMATCH_ON;
            end else if (wired_use && wired_both && servo_on_i) begin
                err_sub_nxt = `ERR_SUB_REQ_SERVO_ON;
            end else if (wired_use && mis_err) begin
                err_sub_nxt = `ERR_SUB_MISMATCH_OFF;
            end else if (!wired_use && wired_req && !net_shutoff_req_i) begin
                err_sub_nxt = `ERR_SUB_PARAM;
            end
        end
    end

    // Alarm state. The stop output is taken from the next error value so the
    // axis stops in the same cycle as the error is latched.
    // A held controller reset keeps the stop low for as long as it stands.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_sub_r   <= `ERR_SUB_NONE;
            warn_a4_o   <= 1'b0;
            axis_stop_o <= 1'b0;
        end else begin
            err_sub_r   <= err_sub_nxt;
            warn_a4_o   <= warn_nxt;
            axis_stop_o <= (err_sub_nxt != `ERR_SUB_NONE);
        end
    end

    // Path A outputs. The echo is taken before the filter so that an outside
    // diagnosis sees the contact itself, chatter included.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            energy_cut_a_o   <= {AXES{1'b0}};
            shutoff_echo_a_o <= 1'b0;
        end else begin
            energy_cut_a_o   <= cut_a_nxt;
            shutoff_echo_a_o <= sync_a;
        end
    end

    // Path B outputs, in a process of their own like the path B logic.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            energy_cut_b_o   <= {AXES{1'b0}};
            shutoff_echo_b_o <= 1'b0;
        end else begin
            energy_cut_b_o   <= cut_b_nxt;
            shutoff_echo_b_o <= sync_b;
        end
    end

    // Event detection for the interrupt status. Each event is a one-cycle pulse
    // taken from registered state, so a level that stands for a long time sets
    // its status bit only once.
    always @* begin
        irq_event = {`IRQ_W{1'b0}};
        irq_event[`IRQ_WARN_BIT]  = warn_a4_o & ~warn_d_r;
        irq_event[`IRQ_ERR_BIT]   = axis_stop_o & ~err_d_r;
        irq_event[`IRQ_INPUT_BIT] = (level_a ^ level_a_d_r) | (level_b ^ level_b_d_r);
    end

    // Previous values for edge detection.
    // They reset to the idle levels, so no false edge follows reset.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warn_d_r    <= 1'b0;
            err_d_r     <= 1'b0;
            level_a_d_r <= 1'b0;
            level_b_d_r <= 1'b0;
        end else begin
            warn_d_r    <= warn_a4_o;
            err_d_r     <= axis_stop_o;
            level_a_d_r <= level_a;
            level_b_d_r <= level_b;
        end
    end

    // Register writes. Interrupt status clears by writing ones; a new event in
    // the same cycle keeps its bit set, so no event is ever lost to a clear.
    // Map, byte addresses on the 8-bit port:
    //   0x00 servo function word eight, bit 8 enables observation of the inputs.
    //   0x04 status, read only: servo on, warning, stop, filtered and synced levels.
    //   0x08 interrupt status, write one to clear: warning, error, input change.
    //   0x0C interrupt mask, same layout as the interrupt status.
    //   0x10 alarm codes: error code, warning code and error sub-number.
    // Unmapped addresses ignore writes; the full address is decoded, so the
    // registers have no aliases.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            func_word_r <= `FUNC_WORD_RESET;
            irq_mask_r  <= {`IRQ_W{1'b0}};
            irq_stat_r  <= {`IRQ_W{1'b0}};
        end else begin
            if (reg_we_i && reg_addr_i == `OFS_SERVO_FUNC_EIGHT) begin
                func_word_r <= reg_wdata_i[`FUNC_WORD_W-1:0];
            end else if (reg_we_i && reg_addr_i == `OFS_IRQ_MASK) begin
                irq_mask_r <= reg_wdata_i[`IRQ_W-1:0];
            end
            if (reg_we_i && reg_addr_i == `OFS_IRQ_STATUS) begin
                irq_stat_r <= (irq_stat_r & ~reg_wdata_i[`IRQ_W-1:0]) | irq_event;
            end else begin
                irq_stat_r <= irq_stat_r | irq_event;
            end
        end
    end

    // Interrupt output, a level while any unmasked status bit is set.
    // The register costs one cycle of latency but keeps the pin free of glitches.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Register reads: data stands for one cycle after the read strobe, zero
    // otherwise and for unmapped addresses. The status word is sampled live,
    // so it shows the levels of the cycle in which the strobe stood; software
    // that needs a history must use the interrupt status instead.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (!reg_re_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_addr_i == `OFS_SERVO_FUNC_EIGHT) begin
            reg_rdata_o <= {16'h0000, func_word_r};
        end else if (reg_addr_i == `OFS_STATUS) begin
            reg_rdata_o <= {24'h000000, 1'b0, sync_b, sync_a, level_b, level_a,
                            axis_stop_o, warn_a4_o, servo_on_i};
        end else if (reg_addr_i == `OFS_IRQ_STATUS) begin
            reg_rdata_o <= {29'h00000000, irq_stat_r};
        end else if (reg_addr_i == `OFS_IRQ_MASK) begin
            reg_rdata_o <= {29'h00000000, irq_mask_r};
        end else if (reg_addr_i == `OFS_ALARM_CODES) begin
            reg_rdata_o <= {(axis_stop_o ? `ERR_CODE : 8'h00),
                            (warn_a4_o ? `WARN_CODE : 8'h00), err_sub_r};
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule

// *** verification/safe_torque_off_monitor_props.sv ***
// Concurrent checks on the ports of the torque-shutoff monitor.
// Assumes one clock domain and small filter counts set by the bench.
`timescale 1ns/1ps

module safe_torque_off_monitor_props #(
    parameter int         AXES            = 4,
    parameter int         LOCAL_AXIS      = 0,
    parameter int         CNT_W           = 24,
    parameter [CNT_W-1:0] FILTER_CYCLES   = 16,
    parameter [CNT_W-1:0] MISMATCH_CYCLES = 20
) (
    input wire logic            clk_i,
    input wire logic            rst_n_i,
    input wire logic            shutoff_in_a_i,
    input wire logic            shutoff_in_b_i,
    input wire logic            net_shutoff_req_i,
    input wire logic            nc_reset_i,
    input wire logic            shutoff_echo_a_o,
    input wire logic            shutoff_echo_b_o,
    input wire logic [AXES-1:0] energy_cut_a_o,
    input wire logic [AXES-1:0] energy_cut_b_o,
    input wire logic            warn_a4_o,
    input wire logic            axis_stop_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    localparam int WITHIN = FILTER_CYCLES + 8;
    logic [7:0] hi_a_r;
    logic [7:0] hi_b_r;

    // Run lengths of a high raw level; they saturate so long holds never wrap.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_a_r <= 8'h00;
            hi_b_r <= 8'h00;
        end else begin
            hi_a_r <= !shutoff_in_a_i ? 8'h00 : (hi_a_r == 8'hFF ? hi_a_r : hi_a_r + 8'h01);
            hi_b_r <= !shutoff_in_b_i ? 8'h00 : (hi_b_r == 8'hFF ? hi_b_r : hi_b_r + 8'h01);
        end
    end

    AST_NET_ALL: assert property (net_shutoff_req_i |=>
        (&energy_cut_a_o) && (&energy_cut_b_o)) else $error("network cut missed an axis");
    AST_WARN_FOLLOWS: assert property (warn_a4_o ==
        ((|energy_cut_a_o) || (|energy_cut_b_o))) else $error("warning does not match cut");
    AST_WIRED_LOCAL: assert property (!net_shutoff_req_i |=>
        (energy_cut_a_o & ~(AXES'(1) << LOCAL_AXIS)) == '0) else $error("wired cut hit other axis");
    AST_ECHO_A: assert property ($rose(shutoff_in_a_i) ##1 shutoff_in_a_i[*2]
        |-> ##1 shutoff_echo_a_o) else $error("echo A did not follow input A");
    AST_ECHO_B: assert property ($fell(shutoff_in_b_i) ##1 !shutoff_in_b_i[*2]
        |-> ##1 !shutoff_echo_b_o) else $error("echo B did not follow input B");
    AST_CUT_A_FILTER: assert property ($rose(energy_cut_a_o[LOCAL_AXIS])
        && !$past(net_shutoff_req_i) |-> hi_a_r >= FILTER_CYCLES) else $error("cut A too early");
    AST_CUT_B_FILTER: assert property ($rose(energy_cut_b_o[LOCAL_AXIS])
        && !$past(net_shutoff_req_i) |-> hi_b_r >= FILTER_CYCLES) else $error("cut B too early");
    AST_CUT_A_WITHIN: assert property (hi_a_r == WITHIN
        |-> energy_cut_a_o[LOCAL_AXIS]) else $error("cut A too late");
    AST_STOP_CLEAR: assert property (nc_reset_i[*3] |-> !axis_stop_o)
        else $error("stop kept through reset request");

    // Main scenarios seen at least once.
    COV_NET: cover property (net_shutoff_req_i ##1 warn_a4_o);
    COV_STOP: cover property ($rose(axis_stop_o));
    COV_ECHO: cover property ($rose(shutoff_echo_a_o));
endmodule

bind safe_torque_off_monitor safe_torque_off_monitor_props #(
    .AXES(AXES), .LOCAL_AXIS(LOCAL_AXIS), .CNT_W(CNT_W),
    .FILTER_CYCLES(FILTER_CYCLES), .MISMATCH_CYCLES(MISMATCH_CYCLES)
) u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .shutoff_in_a_i(shutoff_in_a_i),
    .shutoff_in_b_i(shutoff_in_b_i), .net_shutoff_req_i(net_shutoff_req_i),
    .nc_reset_i(nc_reset_i), .shutoff_echo_a_o(shutoff_echo_a_o),
    .shutoff_echo_b_o(shutoff_echo_b_o), .energy_cut_a_o(energy_cut_a_o),
    .energy_cut_b_o(energy_cut_b_o), .warn_a4_o(warn_a4_o), .axis_stop_o(axis_stop_o)
);

// *** verification/relay_contact_model.sv ***
// Model of the external safety relay that feeds both wired shutoff channels.
// Assumes the bench sets the request and the fault split after clock edges.
`timescale 1ns/1ps

module relay_contact_model (
    input  wire logic req_i,
    input  wire logic split_i,
    output logic      contact_a_o,
    output logic      contact_b_o
);
    // Both contacts carry one request; a split opens channel B as a wiring fault would.
    assign contact_a_o = req_i;
    assign contact_b_o = req_i & ~split_i;
endmodule

// *** verification/safe_torque_off_monitor_test.sv ***
// Self-checking bench for the torque-shutoff monitor with a relay model.
// Assumes short filter counts; the filter and mismatch waits are derived from them.
`timescale 1ns/1ps
`include "shutoff_consts.vh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module safe_torque_off_monitor_test;
    localparam int F = 16;
    localparam int M = 20;
    logic clk_i, rst_n_i, net, servo, ncr, we, re, req, split, in_a, in_b;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic echo_a, echo_b, warn, stop, irq;
    logic [3:0] cut_a, cut_b;
    int mismatches, samples_checked;

    relay_contact_model relay (.req_i(req), .split_i(split), .contact_a_o(in_a),
        .contact_b_o(in_b));
    safe_torque_off_monitor #(.FILTER_CYCLES(24'd16), .MISMATCH_CYCLES(24'd20)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .shutoff_in_a_i(in_a), .shutoff_in_b_i(in_b),
        .net_shutoff_req_i(net), .servo_on_i(servo), .nc_reset_i(ncr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .shutoff_echo_a_o(echo_a), .shutoff_echo_b_o(echo_b), .energy_cut_a_o(cut_a),
        .energy_cut_b_o(cut_b), .warn_a4_o(warn), .axis_stop_o(stop), .irq_o(irq));

    // Free-running clock at 250 MHz.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        we <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_i);
        we <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is looked at there.
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        @(posedge clk_i);
        re <= 1'b1; addr <= a;
        @(posedge clk_i);
        re <= 1'b0;
        #1;
        `CHK(nm, ex, rdata)
    endtask

    // Release the relay, let the filter drop, then clear any latched error.
    task automatic settle();
        @(posedge clk_i);
        req <= 1'b0; split <= 1'b0; servo <= 1'b0;
        cyc(F + 8);
        @(posedge clk_i);
        ncr <= 1'b1;
        cyc(4);
        `CHK("stop", 1'b0, stop)
        @(posedge clk_i);
        ncr <= 1'b0;
        cyc(1);
    endtask

    task automatic t_regs();
        rd(`OFS_SERVO_FUNC_EIGHT, 32'h0000_0000, "fw reset");
        wr(`OFS_SERVO_FUNC_EIGHT, 32'h0000_0100);
        rd(`OFS_SERVO_FUNC_EIGHT, 32'h0000_0100, "fw bit8");
        rd(8'hFC, 32'h0000_0000, "unmapped");
    endtask

    task automatic t_net();
        @(posedge clk_i);
        net <= 1'b1;
        cyc(2);
        `CHK("cut a", 4'hF, cut_a)
        `CHK("cut b", 4'hF, cut_b)
        rd(`OFS_ALARM_CODES, {8'h00, `WARN_CODE, `ERR_SUB_NONE}, "net alarm");
        @(posedge clk_i);
        net <= 1'b0;
        cyc(2);
        `CHK("warn", 1'b0, warn)
    endtask

    task automatic t_wired_ok();
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        @(posedge clk_i);
        req <= 1'b1;
        cyc(4);
        `CHK("echo", 2'b11, {echo_a, echo_b})
        `CHK("early", 4'h0, cut_a)
        cyc(F + 2);
        `CHK("cut", 8'h11, {cut_a, cut_b})
        `CHK("irq", 1'b1, irq)
        rd(`OFS_STATUS, 32'h0000_007A, "status");
        rd(`OFS_IRQ_STATUS, 32'h0000_0005, "irq stat");
        wr(`OFS_IRQ_STATUS, 32'h0000_0007);
        cyc(2);
        `CHK("irq clr", 1'b0, irq)
        `CHK("stop", 1'b0, stop)
        settle();
        `CHK("echo off", 2'b00, {echo_a, echo_b})
        `CHK("cut off", 8'h00, {cut_a, cut_b})
    endtask

    // One wired case: configuration, servo, split and the alarm word expected.
    task automatic t_fault(input logic use_w, input logic sv, input logic sp,
                           input logic [15:0] sub, input string nm);
        wr(`OFS_SERVO_FUNC_EIGHT, {23'h0, use_w, 8'h00});
        @(posedge clk_i);
        servo <= sv; split <= sp; req <= 1'b1;
        cyc(F + M + 10);
        `CHK(nm, 1'b1, stop)
        `CHK("cut", 1'b1, cut_a[0])
        rd(`OFS_ALARM_CODES, {`ERR_CODE, `WARN_CODE, sub}, nm);
        settle();
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the scenarios need.
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        {net, servo, ncr, we, re, req, split} = '0;
        addr = 8'h00;
        wdata = 32'h0;
        rst_n_i = 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_net();
        t_wired_ok();
        t_fault(1'b1, 1'b0, 1'b1, `ERR_SUB_MISMATCH_OFF, "mismatch off");
        t_fault(1'b1, 1'b1, 1'b0, `ERR_SUB_REQ_SERVO_ON, "servo on");
        t_fault(1'b1, 1'b1, 1'b1, `ERR_SUB_MISMATCH_ON, "mismatch on");
        t_fault(1'b0, 1'b0, 1'b0, `ERR_SUB_PARAM, "unused");
        end_of_test();
    end
endmodule
